// ### rtl/adcdc_ctrl.sv
// converter mode, sequencing, interrupt and dma address control with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "adcdc_defs.svh"

// Functional notes
// - resolution bit: 10-bit four S/H default, 12-bit single
// - channel select covers inputs zero through twelve
// - 10-bit conversions paced to 1.1 Msps
// - 10-bit mode samples up to four inputs together
// - 12-bit: 500 ksps, one S/H, no simultaneous
// - keeps converting during cpu sleep, and during idle unless stop-in-idle is set
// - dma request each time group flag sets
// - increment-rate field sets sequences per dma step
// - build-mode set: addresses in conversion order
// - build-mode clear: address from channel and size
module adcdc_ctrl
  import adcdc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end
  output logic [12:0] analog_enable,
  output logic [3:0] analog_select,
  output logic [3:0] sample_hold,
  output logic [2:0] vref_select,
  input wire logic [11:0] sar_data,
  // power state of the cpu
  input wire logic cpu_idle,
  // dma channel
  output logic dma_valid,
  output logic [15:0] dma_addr,
  output logic [15:0] dma_data,
  output logic [3:0] dma_chan,
  input wire logic dma_ready,
  output logic dma_req,
  // interrupt
  output logic irq
);

  adcdc_regs_type q, n;
  logic twelve;
  logic [2:0] nsh;
  logic [15:0] conv_cyc;
  logic [15:0] samp_cyc;
  logic wr_en;

  // =========================================================
  // helpers
  function automatic logic [2:0] sh_count(input logic is12, input logic [1:0] fld);
    if (is12)
      return 3'h1;
    else if (fld == 2'h0)
      return 3'h1;
    else if (fld == 2'h1)
      return 3'h2;
    else
      return 3'h4;
  endfunction

  function automatic logic [3:0] chan_of(input logic [3:0] base, input logic [1:0] idx);
    logic [4:0] s;
    s = {1'b0, base} + {3'h0, idx};
    if (s >= `ADCDC_NUM_CHAN)
      s = s - `ADCDC_NUM_CHAN;
    if (s > {1'b0, `ADCDC_LAST_CHAN})
      s = {1'b0, `ADCDC_LAST_CHAN};
    return s[3:0];
  endfunction

  // integer, signed integer, fraction, signed fraction
  function automatic logic [15:0] fmt(input logic [11:0] raw, input logic is12, input logic [1:0] form);
    logic [15:0] v;
    v = is12 ? {4'h0, raw} : {6'h00, raw[9:0]};
    if (form[0])
      v = is12 ? {{5{~raw[11]}}, raw[10:0]} : {{7{~raw[9]}}, raw[8:0]};
    if (form[1])
      v = is12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
    if (form == 2'h3)
      v = is12 ? {~raw[11], raw[10:0], 4'h0} : {~raw[9], raw[8:0], 6'h00};
    return v;
  endfunction

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // =========================================================
  // mode decode
  assign twelve = q.c1[`ADCDC_C1_RES];
  assign nsh = sh_count(twelve, q.c2[`ADCDC_C2_SHCNT]);
  assign samp_cyc = 16'(({1'b0, q.c3[`ADCDC_C3_SAMC]} + 6'h01) * ({1'b0, q.c3[`ADCDC_C3_CLK]} + 9'h001));

  // conversion length is the slower of the tad count and the throughput ceiling
  always_comb
  begin
    conv_cyc = 16'(((twelve ? `ADCDC_BITS12 : `ADCDC_BITS10) + `ADCDC_CONV_EXTRA)
      * ({1'b0, q.c3[`ADCDC_C3_CLK]} + 9'h001));
    if (twelve && conv_cyc < 16'(`ADCDC_MIN12_CYC))
      conv_cyc = 16'(`ADCDC_MIN12_CYC);
    if (!twelve && conv_cyc < 16'(`ADCDC_MIN10_CYC))
      conv_cyc = 16'(`ADCDC_MIN10_CYC);
  end

  assign wr_en = psel && penable && pwrite;

  // =========================================================
  // next state
  always_comb
  begin
    n = q;
    n.dma_req = 1'b0;
    if (psel && !penable)
    begin
      n.prdata = 32'h0000_0000;
      if (is_off(paddr, `ADCDC_OFF_CTRL_ONE))
        n.prdata = {16'h0000, q.c1};
      else if (is_off(paddr, `ADCDC_OFF_CTRL_TWO))
        n.prdata = {16'h0000, q.c2};
      else if (is_off(paddr, `ADCDC_OFF_CTRL_THREE))
        n.prdata = {16'h0000, q.c3};
      else if (is_off(paddr, `ADCDC_OFF_CHAN_SEL))
        n.prdata = {28'h0000000, q.chsel};
      else if (is_off(paddr, `ADCDC_OFF_PIN_CFG))
        n.prdata = {19'h00000, q.pcfg};
      else if (is_off(paddr, `ADCDC_OFF_DMA_BUF))
        n.prdata = {24'h000000, q.bufsz};
      else if (is_off(paddr, `ADCDC_OFF_IRQ_STATUS))
        n.prdata = {30'h00000000, q.ist};
      else if (is_off(paddr, `ADCDC_OFF_IRQ_ENABLE))
        n.prdata = {30'h00000000, q.ien};
      else if (is_off(paddr, `ADCDC_OFF_RESULT))
        n.prdata = {12'h000, q.res_ch, q.res_data};
      else if (is_off(paddr, `ADCDC_OFF_STATUS))
        n.prdata = {22'h000000, q.wptr, q.seq_cnt, q.st};
    end
    if (wr_en)
    begin
      if (is_off(paddr, `ADCDC_OFF_CTRL_ONE))
      begin
        n.c1 = pwdata[15:0] & `ADCDC_C1_MASK;
        // done is read/clear: software may only clear it
        n.c1[`ADCDC_C1_DONE] = q.c1[`ADCDC_C1_DONE] & pwdata[`ADCDC_C1_DONE];
      end
      else if (is_off(paddr, `ADCDC_OFF_CTRL_TWO))
        n.c2 = pwdata[15:0] & `ADCDC_C2_MASK;
      else if (is_off(paddr, `ADCDC_OFF_CTRL_THREE))
        n.c3 = pwdata[15:0] & `ADCDC_C3_MASK;
      else if (is_off(paddr, `ADCDC_OFF_CHAN_SEL))
        n.chsel = (pwdata[3:0] > `ADCDC_LAST_CHAN) ? `ADCDC_LAST_CHAN : pwdata[3:0];
      else if (is_off(paddr, `ADCDC_OFF_PIN_CFG))
        n.pcfg = pwdata[12:0];
      else if (is_off(paddr, `ADCDC_OFF_DMA_BUF))
        n.bufsz = pwdata[7:0];
      else if (is_off(paddr, `ADCDC_OFF_IRQ_ENABLE))
        n.ien = pwdata[1:0];
      else if (is_off(paddr, `ADCDC_OFF_IRQ_CLEAR))
        n.ist = q.ist & ~pwdata[1:0];
    end
    // sequencer runs after the bus so a hardware set wins over a same-cycle clear
    if (!q.c1[`ADCDC_C1_ON])
    begin
      n.st = ADCDC_IDLE;
      n.dma_valid = 1'b0;
      n.seq_cnt = 4'h0;
      n.cnt = 16'h0000;
    end
    else if (q.c1[`ADCDC_C1_SIDL] && cpu_idle)
    begin
      // stop-in-idle freezes the sequence; otherwise idle and sleep do not matter
      n.st = q.st;
    end
    else
    begin
      unique case (q.st)
        ADCDC_IDLE:
        begin
          if (q.c1[`ADCDC_C1_SAMP] || q.c1[`ADCDC_C1_ASAM])
          begin
            n.st = ADCDC_SAMPLE;
            n.sh_idx = 2'h0;
            n.cnt = samp_cyc - 16'h0001;
          end
        end
        ADCDC_SAMPLE:
        begin
          if (q.cnt == 16'h0000)
          begin
            n.st = ADCDC_CONVERT;
            n.cnt = conv_cyc - 16'h0001;
            n.c1[`ADCDC_C1_SAMP] = 1'b0;
          end
          else
            n.cnt = q.cnt - 16'h0001;
        end
        ADCDC_CONVERT:
        begin
          if (q.cnt == 16'h0000)
          begin
            n.st = ADCDC_DELIVER;
            n.res_data = fmt(sar_data, twelve, q.c1[`ADCDC_C1_FORM]);
            n.res_ch = chan_of(q.chsel, q.sh_idx);
            n.dma_valid = 1'b1;
            if (q.c1[`ADCDC_C1_DMABM])
              n.dma_addr = {12'h000, q.wptr};
            else
              n.dma_addr = 16'({4'h0, chan_of(q.chsel, q.sh_idx)} * q.bufsz) + {8'h00, q.slot};
          end
          else
            n.cnt = q.cnt - 16'h0001;
        end
        ADCDC_DELIVER:
        begin
          if (dma_ready)
          begin
            n.dma_valid = 1'b0;
            n.wptr = q.wptr + 4'h1;
            if ({1'b0, q.sh_idx} == nsh - 3'h1)
            begin
              n.st = ADCDC_IDLE;
              n.c1[`ADCDC_C1_DONE] = 1'b1;
              n.ist[`ADCDC_IRQ_SEQ] = 1'b1;
              n.seq_cnt = q.seq_cnt + 4'h1;
              if (q.seq_cnt == q.c2[`ADCDC_C2_RATE])
              begin
                n.seq_cnt = 4'h0;
                n.ist[`ADCDC_IRQ_GROUP] = 1'b1;
                n.dma_req = 1'b1;
                n.slot = ({1'b0, q.slot} + 9'h001 >= {1'b0, q.bufsz}) ? 8'h00 : q.slot + 8'h01;
              end
            end
            else
            begin
              n.sh_idx = q.sh_idx + 2'h1;
              // without simultaneous sampling each holder samples just before its conversion
              if (q.c1[`ADCDC_C1_SIMSAM] && !twelve)
              begin
                n.st = ADCDC_CONVERT;
                n.cnt = conv_cyc - 16'h0001;
              end
              else
              begin
                n.st = ADCDC_SAMPLE;
                n.cnt = samp_cyc - 16'h0001;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '{st: ADCDC_IDLE, c1: `ADCDC_C1_RESET, default: '0};
    else
      q <= n;
  end

  // =========================================================
  // outputs
  assign prdata = q.prdata;
  assign pready = psel && penable;
  assign pslverr = 1'b0;
  assign analog_enable = q.pcfg;
  assign analog_select = chan_of(q.chsel, q.sh_idx);
  assign vref_select = q.c2[`ADCDC_C2_VREF];
  assign dma_valid = q.dma_valid;
  assign dma_addr = q.dma_addr;
  assign dma_data = q.res_data;
  assign dma_chan = q.res_ch;
  assign dma_req = q.dma_req;
  assign irq = |(q.ist & q.ien);

  always_comb
  begin
    sample_hold = 4'h0;
    if (q.st == ADCDC_SAMPLE)
    begin
      if (q.c1[`ADCDC_C1_SIMSAM] && !twelve)
        sample_hold = (nsh == 3'h4) ? 4'hf : ((nsh == 3'h2) ? 4'h3 : 4'h1);
      else
        sample_hold = 4'(4'h1 << q.sh_idx);
    end
  end

  // =========================================================
  // checks
  logic [15:0] conv_len;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_len <= 16'h0000;
    else if (q.st == ADCDC_CONVERT)
      conv_len <= conv_len + 16'h0001;
    else
      conv_len <= 16'h0000;
  end

  a_rate_ten: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCDC_CONVERT && n.st == ADCDC_DELIVER && !twelve) |-> conv_len + 16'h0001 >= 16'(`ADCDC_MIN10_CYC))
    else $error("10-bit conversion shorter than throughput limit");
  a_rate_twelve: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCDC_CONVERT && n.st == ADCDC_DELIVER && twelve) |-> conv_len + 16'h0001 >= 16'(`ADCDC_MIN12_CYC))
    else $error("12-bit conversion shorter than throughput limit");
  a_single_holder: assert property (@(posedge pclk) disable iff (!presetn)
    (twelve && q.st != ADCDC_IDLE) |-> q.sh_idx == 2'h0 && !sample_hold[1] && !sample_hold[3])
    else $error("second sample/hold used in 12-bit mode");
  a_four_together: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ADCDC_SAMPLE && !twelve && q.c1[`ADCDC_C1_SIMSAM] && q.c2[`ADCDC_C2_SHCNT] >= 2'h2) |-> sample_hold == 4'hf)
    else $error("simultaneous sampling missed a holder");
  a_chan_range: assert property (@(posedge pclk) disable iff (!presetn)
    analog_select <= `ADCDC_LAST_CHAN)
    else $error("channel select beyond last input");
  a_flag_dma: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req |-> q.ist[`ADCDC_IRQ_GROUP] && $past(q.seq_cnt) == $past(q.c2[`ADCDC_C2_RATE]))
    else $error("dma request without group flag");
  a_group_size: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.ist[`ADCDC_IRQ_GROUP]) |-> $past(q.seq_cnt) == $past(q.c2[`ADCDC_C2_RATE]) && q.seq_cnt == 4'h0)
    else $error("group flag set off the increment rate");
  a_flag_held: assert property (@(posedge pclk) disable iff (!presetn)
    (q.ist[`ADCDC_IRQ_GROUP] && !(wr_en && paddr == `ADCDC_OFF_IRQ_CLEAR && pwdata[0])) |=> q.ist[`ADCDC_IRQ_GROUP])
    else $error("group flag dropped without clear");
  a_order_addr: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dma_valid) && q.c1[`ADCDC_C1_DMABM] |-> dma_addr == {12'h000, q.wptr})
    else $error("conversion-order address wrong");
  a_scatter_addr: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dma_valid) && !q.c1[`ADCDC_C1_DMABM] |-> dma_addr == 16'({4'h0, dma_chan} * q.bufsz) + {8'h00, q.slot})
    else $error("scatter/gather address wrong");
  a_idle_runs: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_idle && !wr_en && !q.c1[`ADCDC_C1_SIDL] && q.c1[`ADCDC_C1_ON] && q.st == ADCDC_SAMPLE && q.cnt != 16'h0000)
    |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("sampling stalled in cpu idle");
  c_group_done: cover property (@(posedge pclk) disable iff (!presetn) dma_req);
  c_sim_four: cover property (@(posedge pclk) disable iff (!presetn) sample_hold == 4'hf);
  c_twelve_conv: cover property (@(posedge pclk) disable iff (!presetn) twelve && $rose(dma_valid));
  c_dma_stall: cover property (@(posedge pclk) disable iff (!presetn) dma_valid && !dma_ready ##1 dma_valid);
endmodule
`default_nettype wire

// ### pkg/adcdc_defs.svh
// register map, field positions and timing constants of the converter control block
`ifndef ADCDC_DEFS_SVH
`define ADCDC_DEFS_SVH
// register byte offsets
`define ADCDC_OFF_CTRL_ONE 8'h00
`define ADCDC_OFF_CTRL_TWO 8'h04
`define ADCDC_OFF_CTRL_THREE 8'h08
`define ADCDC_OFF_CHAN_SEL 8'h0c
`define ADCDC_OFF_PIN_CFG 8'h10
`define ADCDC_OFF_DMA_BUF 8'h14
`define ADCDC_OFF_IRQ_STATUS 8'h18
`define ADCDC_OFF_IRQ_ENABLE 8'h1c
`define ADCDC_OFF_IRQ_CLEAR 8'h20
`define ADCDC_OFF_RESULT 8'h24
`define ADCDC_OFF_STATUS 8'h28
// converter_control_one fields
`define ADCDC_C1_ON 15
`define ADCDC_C1_SIDL 13
`define ADCDC_C1_DMABM 12
`define ADCDC_C1_RES 10
`define ADCDC_C1_FORM 9:8
`define ADCDC_C1_SIMSAM 3
`define ADCDC_C1_ASAM 2
`define ADCDC_C1_SAMP 1
`define ADCDC_C1_DONE 0
`define ADCDC_C1_MASK 16'hb70f
`define ADCDC_C1_RESET 16'h0000
// converter_control_two fields
`define ADCDC_C2_VREF 15:13
`define ADCDC_C2_SHCNT 9:8
`define ADCDC_C2_RATE 5:2
`define ADCDC_C2_MASK 16'he33c
// converter_control_three fields
`define ADCDC_C3_SAMC 12:8
`define ADCDC_C3_CLK 7:0
`define ADCDC_C3_MASK 16'h1fff
// interrupt bits
`define ADCDC_IRQ_GROUP 0
`define ADCDC_IRQ_SEQ 1
// channel count and resolution figures
`define ADCDC_NUM_CHAN 5'd13
`define ADCDC_LAST_CHAN 4'hc
`define ADCDC_BITS10 5'd10
`define ADCDC_BITS12 5'd12
`define ADCDC_CONV_EXTRA 5'd2
// timing: clock rate and the documented peak throughputs
`define ADCDC_CLK_HZ 10000000
`define ADCDC_RATE10_SPS 1100000
`define ADCDC_RATE12_SPS 500000
`define ADCDC_MIN10_CYC ((`ADCDC_CLK_HZ + `ADCDC_RATE10_SPS - 1) / `ADCDC_RATE10_SPS)
`define ADCDC_MIN12_CYC ((`ADCDC_CLK_HZ + `ADCDC_RATE12_SPS - 1) / `ADCDC_RATE12_SPS)
`endif

// ### pkg/adcdc_pkg.sv
// types of the converter control block
package adcdc_pkg;
  typedef enum logic [1:0] {
    ADCDC_IDLE = 2'b00,
    ADCDC_SAMPLE = 2'b01,
    ADCDC_CONVERT = 2'b10,
    ADCDC_DELIVER = 2'b11
  } adcdc_state_type;

  typedef struct packed {
    adcdc_state_type st;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] c3;
    logic [3:0] chsel;
    logic [12:0] pcfg;
    logic [7:0] bufsz;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [15:0] cnt;
    logic [1:0] sh_idx;
    logic [3:0] seq_cnt;
    logic [3:0] wptr;
    logic [7:0] slot;
    logic [15:0] res_data;
    logic [3:0] res_ch;
    logic dma_valid;
    logic [15:0] dma_addr;
    logic dma_req;
    logic [31:0] prdata;
  } adcdc_regs_type;
endpackage

// ### verification/adcdc_dma_model.sv
// dma channel model that takes converter results, with a stall input
`timescale 1ns/1ps
`default_nettype none
module adcdc_dma_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // result stream
  input wire logic dma_valid,
  input wire logic [15:0] dma_addr,
  input wire logic [3:0] dma_chan,
  input wire logic dma_req,
  output logic dma_ready,
  // bench control and statistics
  input wire logic stall,
  output logic [15:0] last_addr,
  output logic [3:0] last_chan,
  output int n_acc,
  output int n_req,
  output int last_gap,
  output int n_unstable
);
  logic hold;
  logic [15:0] held_addr;
  int gap;
  // ==========================================================
  // acceptance
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_ready <= 1'b0;
      last_addr <= 16'h0000;
      last_chan <= 4'h0;
      n_acc <= 0;
      n_req <= 0;
      last_gap <= 0;
      n_unstable <= 0;
      hold <= 1'b0;
      held_addr <= 16'h0000;
      gap <= 0;
    end
    else
    begin
      dma_ready <= !stall;
      gap <= gap + 1;
      if (dma_valid && dma_ready)
      begin
        // address kept for order and scatter checks
        n_acc <= n_acc + 1;
        last_addr <= dma_addr;
        last_chan <= dma_chan;
        last_gap <= gap;
        gap <= 0;
      end
      if (dma_req)
        n_req <= n_req + 1;
      // a held result address must not move while the channel stalls
      if (hold && dma_valid && dma_addr !== held_addr)
        n_unstable <= n_unstable + 1;
      hold <= dma_valid && !dma_ready;
      held_addr <= dma_addr;
    end
  end
endmodule
`default_nettype wire

// ### verification/adcdc_ctrl_tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcdc_ctrl_tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} adcdc_row_type;
  logic pclk = 1'b0;
  logic sar_freeze = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, cpu_idle, dma_valid, dma_ready, dma_req, irq, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] analog_enable;
  logic [3:0] analog_select, sample_hold, dma_chan, last_chan;
  logic [3:0] sh_last = 4'h0;
  logic [2:0] vref_select;
  logic [11:0] sar_data = 12'h5a3;
  logic [15:0] dma_addr, dma_data, last_addr;
  int n_acc, n_req, last_gap, n_unstable, n_mismatch, tests_run, acc0;
  adcdc_row_type rows[9] = '{'{8'h04, 32'hffffffff, 32'h0000e33c}, '{8'h08, 32'hffffffff, 32'h00001fff},
    '{8'h0c, 32'h0000000f, 32'h0000000c}, '{8'h10, 32'hffffffff, 32'h00001fff}, '{8'h14, 32'h000001ff, 32'h000000ff},
    '{8'h18, 32'h00000003, 32'h00000000}, '{8'h20, 32'h00000003, 32'h00000000}, '{8'h40, 32'h12345678, 32'h00000000},
    '{8'h1c, 32'h00000003, 32'h00000003}};
  adcdc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_enable(analog_enable),
    .analog_select(analog_select), .sample_hold(sample_hold), .vref_select(vref_select), .sar_data(sar_data),
    .cpu_idle(cpu_idle), .dma_valid(dma_valid), .dma_addr(dma_addr), .dma_data(dma_data), .dma_chan(dma_chan),
    .dma_ready(dma_ready), .dma_req(dma_req), .irq(irq));
  adcdc_dma_model i_dma (.pclk(pclk), .presetn(presetn), .dma_valid(dma_valid), .dma_addr(dma_addr),
    .dma_chan(dma_chan), .dma_req(dma_req), .dma_ready(dma_ready), .stall(stall), .last_addr(last_addr),
    .last_chan(last_chan), .n_acc(n_acc), .n_req(n_req), .last_gap(last_gap), .n_unstable(n_unstable));
  // ==========================================================
  // clock, front end data and holder strobe capture
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    // a frozen front end gives a known code for the result format checks
    sar_data <= sar_freeze ? 12'ha5c : sar_data + 12'h001;
    if (sample_hold !== 4'h0)
      sh_last <= sample_hold;
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a stuck transfer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_acc(input int n);
    while (n_acc < n)
      @(posedge pclk);
  endtask
  // one more edge so the model has counted the request pulse that comes with the flag
  task automatic wait_irq;
    while (irq !== 1'b1)
      @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // watchdog, far above the expected few hundred cycles
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    cpu_idle = 0; stall = 0; n_mismatch = 0; tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(irq, 1'b0);
    check(dma_valid, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].e);
    end
    check(pslverr, 1'b0);
    check(analog_enable, 13'h1fff);
    check(vref_select, 3'h7);
    // 10-bit, four holders together, conversion order, group of two
    apb(1'b1, 8'h10, 32'h0000000f);
    apb(1'b1, 8'h04, 32'h00002204);
    apb(1'b1, 8'h08, 32'h00000000);
    apb(1'b1, 8'h0c, 32'h00000000);
    apb(1'b1, 8'h20, 32'h00000003);
    apb(1'b1, 8'h1c, 32'h00000001);
    apb(1'b1, 8'h00, 32'h0000900a);
    wait_acc(4);
    check(last_addr, 16'h0003);
    check(last_chan, 4'h3);
    check(sh_last, 4'hf);
    check(last_gap >= 9, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd[0], 1'b1);
    check(n_req, 0);
    apb(1'b1, 8'h00, 32'h0000900a);
    wait_acc(8);
    wait_irq();
    check(last_addr, 16'h0007);
    check(n_req, 1);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h3);
    repeat (20) @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b1, 8'h1c, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, 8'h1c, 32'h1);
    check(irq, 1'b1);
    apb(1'b1, 8'h20, 32'h1);
    check(irq, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h2);
    // 12-bit scatter with the cpu idle and the channel stalling; the slot already moved once
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h00000400);
    apb(1'b1, 8'h0c, 32'h5);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h04, 32'h00002200);
    apb(1'b1, 8'h08, 32'h00000100);
    cpu_idle <= 1'b1;
    stall <= 1'b1;
    sar_freeze <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000840a);
    repeat (80) @(posedge pclk);
    check(dma_valid, 1'b1);
    check(dma_addr, 16'd21);
    check(dma_chan, 4'h5);
    check(dma_data, 16'h0a5c);
    check(n_acc, 8);
    stall <= 1'b0;
    wait_irq();
    check(n_acc, 9);
    check(sh_last, 4'h1);
    check(n_req, 2);
    apb(1'b1, 8'h20, 32'h3);
    apb(1'b1, 8'h00, 32'h0000860a);
    wait_irq();
    check(last_addr, 16'd22);
    check(dma_data, 16'ha5c0);
    // continuous 12-bit sampling keeps to the slower pace
    apb(1'b1, 8'h00, 32'h00008404);
    wait_acc(13);
    check(last_gap >= 19, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    @(posedge pclk);
    check(dma_valid, 1'b0);
    check(n_unstable, 0);
    // stop-in-idle holds the sequence until the cpu wakes
    acc0 = n_acc;
    apb(1'b1, 8'h00, 32'h0000a40a);
    repeat (40) @(posedge pclk);
    check(n_acc, acc0);
    cpu_idle <= 1'b0;
    wait_acc(acc0 + 1);
    check(last_chan, 4'h5);
    // reset in mid-run brings every register back to its default
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(irq, 1'b0);
    check(dma_valid, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
